// ==== src/dpsc_pkg.sv ====
// constants, types and helpers shared by the dual pot serial command block
// assumes one system clock at 50 MHz and a two-wire bus whose clock is the link clock
package dpsc_pkg;

    localparam int unsigned NUM_POTS        = 2;
    localparam int unsigned STORED_PER_POT  = 4;
    localparam int unsigned STORED_NUM      = NUM_POTS * STORED_PER_POT;
    localparam int unsigned WIPER_W         = 6;
    localparam int unsigned TAPS            = 64;
    localparam int unsigned BYTE_W          = 8;

    // nonvolatile write time
    localparam int unsigned CLK_PERIOD_NS    = 20;
    localparam int unsigned NV_WRITE_TIME_MS = 10;
    localparam int unsigned NV_WRITE_CYCLES  = NV_WRITE_TIME_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int unsigned NV_CNT_W         = 19;

    // instruction byte fields
    localparam int unsigned OPC_MSB    = 7;
    localparam int unsigned OPC_LSB    = 4;
    localparam int unsigned ADDR_MSB   = 3;
    localparam int unsigned SEL_MSB    = 3;
    localparam int unsigned SEL_LSB    = 2;
    localparam int unsigned POT_BIT    = 0;
    localparam int unsigned TX_NEXT    = 6;

    // opcodes
    localparam logic [3:0] OP_RD_WIPER  = 4'h9;
    localparam logic [3:0] OP_WR_WIPER  = 4'hA;
    localparam logic [3:0] OP_RD_STORED = 4'hB;
    localparam logic [3:0] OP_WR_STORED = 4'hC;
    localparam logic [3:0] OP_S2W       = 4'hD;
    localparam logic [3:0] OP_W2S       = 4'hE;
    localparam logic [3:0] OP_STEP      = 4'h2;

    // bit slot counter
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE  = 4'h1;
    localparam logic [3:0] CNT_LAST = 4'h7;
    localparam logic [3:0] CNT_ACK  = 4'h8;

    localparam logic [5:0] WIPER_ONE = 6'h01;
    localparam logic [5:0] WIPER_MAX = 6'h3F;
    localparam logic [5:0] WIPER_MIN = 6'h00;
    localparam logic [1:0] SEL_ZERO  = 2'h0;
    localparam logic [1:0] LEAD_ZERO = 2'h0;

    typedef enum logic [2:0] {
        DPSC_IDLE  = 3'b000,
        DPSC_ADDR  = 3'b001,
        DPSC_INSTR = 3'b010,
        DPSC_WDATA = 3'b011,
        DPSC_RDATA = 3'b100,
        DPSC_STEP  = 3'b101,
        DPSC_DONE  = 3'b110
    } dpsc_state_type;

    typedef struct packed {
        logic [3:0]         opcode;
        logic               pot;
        logic [1:0]         sel;
        logic [WIPER_W-1:0] data;
    } dpsc_cmd_type;

    function automatic logic [2:0] stored_index(input logic pot, input logic [1:0] sel);
        return {pot, sel};
    endfunction : stored_index

    function automatic logic [TAPS-1:0] tap_decode(input logic [WIPER_W-1:0] pos);
        logic [TAPS-1:0] onehot;
        onehot      = '0;
        onehot[pos] = 1'b1;
        return onehot;
    endfunction : tap_decode

    function automatic logic opcode_known(input logic [3:0] op);
        return (op == OP_RD_WIPER) || (op == OP_WR_WIPER) || (op == OP_RD_STORED) ||
               (op == OP_WR_STORED) || (op == OP_S2W) || (op == OP_W2S) || (op == OP_STEP);
    endfunction : opcode_known

endpackage : dpsc_pkg

// ==== src/dpsc_top.sv ====
// serial command decoder and register set of a dual digital potentiometer
// assumes scl_i is made by the bus master and stands still between frames,
// sda is open drain with an outside pull-up, rstn_i is the power-up event
`timescale 1ns/1ps
module dpsc_top
    import dpsc_pkg::*;
#(
    parameter logic [3:0]  DEVICE_TYPE_ID    = 4'h6,  // arbitrary value
    parameter int unsigned NV_WRITE_CYCLES_P = NV_WRITE_CYCLES
) (
    // system clock and reset
    input  wire logic                              clock_i,
    input  wire logic                              rstn_i,
    // two-wire bus
    input  wire logic                              scl_i,
    input  wire logic                              sda_i,
    output logic                                   sda_o,
    output logic                                   sda_oe_o,
    // address straps
    input  wire logic [ADDR_MSB:0]                 device_address_bits_i,
    // potentiometer side
    output logic [NUM_POTS-1:0][WIPER_W-1:0]       wiper_position_o,
    output logic [NUM_POTS-1:0][TAPS-1:0]          tap_select_o,
    output logic                                   nv_busy_o
);

    // ---------------- system domain state ----------------
    logic [NUM_POTS-1:0][WIPER_W-1:0]   wiper_position_register_r;
    logic [NUM_POTS-1:0][TAPS-1:0]      tap_r;
    // nonvolatile: never touched by reset
    logic [STORED_NUM-1:0][WIPER_W-1:0] stored_setting_register_r = '0;
    logic                               busy_r;
    logic [NV_CNT_W-1:0]                nv_cnt_r;
    logic [2:0]                         nv_idx_r;
    logic [WIPER_W-1:0]                 nv_data_r;

    // ---------------- link domain state ----------------
    // scl may not run during reset, so these start defined
    logic                               start_tgl_r  = 1'b0;
    logic                               stop_tgl_r   = 1'b0;
    logic                               start_seen_r = 1'b0;
    dpsc_state_type                     state_r      = DPSC_IDLE;
    logic                               oe_r         = 1'b0;
    logic                               sda_out_r    = 1'b0;
    logic                               cmd_ready_r  = 1'b0;
    logic                               step_tgl_r   = 1'b0;
    logic                               step_up_r    = 1'b0;
    logic [3:0]                         cnt_r        = CNT_ZERO;
    logic [BYTE_W-1:0]                  shift_r      = '0;
    logic [BYTE_W-1:0]                  tx_r         = '0;
    dpsc_cmd_type                       cmd_r        = '0;
    logic                               sda_bit_r    = 1'b0;

    // link-side synchronisers
    // start out of reset: the link state is already idle from its initialisers
    logic                               lrst_s1_r    = 1'b1;
    logic                               lrst_s2_r    = 1'b1;
    logic                               busy_s1_r, busy_s2_r;
    logic [ADDR_MSB:0]                  addr_s1_r, addr_s2_r;
    logic [NUM_POTS-1:0][WIPER_W-1:0]   wip_s1_r, wip_s2_r;
    logic [STORED_NUM-1:0][WIPER_W-1:0] sto_s1_r, sto_s2_r;

    // system-side synchronisers
    logic                               stop_s1_r, stop_s2_r, stop_s3_r;
    logic                               rdy_s1_r, rdy_s2_r;
    logic                               step_s1_r, step_s2_r, step_s3_r;

    logic                               stop_evt;
    logic                               step_evt;
    logic                               exec;
    logic [BYTE_W-1:0]                  byte_w;
    logic                               addr_hit;
    logic [WIPER_W-1:0]                 rd_val;

    // ================= bus edge detection =================
    // start: sda falls while scl high
    always_ff @(negedge sda_i) begin
        if (scl_i) begin
            start_tgl_r <= ~start_tgl_r;
        end
    end

    // stop: sda rises while scl high
    always_ff @(posedge sda_i) begin
        if (scl_i) begin
            stop_tgl_r <= ~stop_tgl_r;
        end
    end

    // data is valid at the rising edge of scl
    always_ff @(posedge scl_i) begin
        sda_bit_r <= sda_i;
    end

    // ================= link domain synchronisers =================
    always_ff @(negedge scl_i) begin
        lrst_s1_r <= rstn_i;
        lrst_s2_r <= lrst_s1_r;
        busy_s1_r <= busy_r;
        busy_s2_r <= busy_s1_r;
        addr_s1_r <= device_address_bits_i;
        addr_s2_r <= addr_s1_r;
        wip_s1_r  <= wiper_position_register_r;
        wip_s2_r  <= wip_s1_r;
        sto_s1_r  <= stored_setting_register_r;
        sto_s2_r  <= sto_s1_r;
    end

    assign byte_w   = {shift_r[BYTE_W-2:0], sda_bit_r};
    assign addr_hit = (byte_w[OPC_MSB:OPC_LSB] == DEVICE_TYPE_ID) &&
                      (byte_w[ADDR_MSB:0] == addr_s2_r) && !busy_s2_r;
    assign rd_val   = (cmd_r.opcode == OP_RD_WIPER) ? wip_s2_r[cmd_r.pot]
                    : sto_s2_r[stored_index(cmd_r.pot, cmd_r.sel)];

    // ================= link domain frame engine =================
    // start_tgl_r changed during scl high and is settled by this falling edge
    always_ff @(negedge scl_i) begin
        sda_out_r <= 1'b0;
        if (!lrst_s2_r) begin
            start_seen_r <= start_tgl_r;
            state_r      <= DPSC_IDLE;
            oe_r         <= 1'b0;
            cmd_ready_r  <= 1'b0;
            cnt_r        <= CNT_ZERO;
        end else if (start_tgl_r != start_seen_r) begin
            // new frame, also on a repeated start
            start_seen_r <= start_tgl_r;
            state_r      <= DPSC_ADDR;
            oe_r         <= 1'b0;
            cmd_ready_r  <= 1'b0;
            cnt_r        <= CNT_ZERO;
        end else begin
            case (state_r)
                DPSC_ADDR: begin
                    if (cnt_r != CNT_ACK) begin
                        shift_r <= byte_w;
                        cnt_r   <= cnt_r + CNT_ONE;
                        if (cnt_r == CNT_LAST) begin
                            oe_r <= addr_hit;
                        end
                    end else begin
                        oe_r    <= 1'b0;
                        cnt_r   <= CNT_ZERO;
                        state_r <= oe_r ? DPSC_INSTR : DPSC_IDLE;
                    end
                end
                DPSC_INSTR: begin
                    if (cnt_r != CNT_ACK) begin
                        shift_r <= byte_w;
                        cnt_r   <= cnt_r + CNT_ONE;
                        if (cnt_r == CNT_LAST) begin
                            oe_r         <= opcode_known(byte_w[OPC_MSB:OPC_LSB]);
                            cmd_r.opcode <= byte_w[OPC_MSB:OPC_LSB];
                            cmd_r.sel    <= byte_w[SEL_MSB:SEL_LSB];
                            cmd_r.pot    <= byte_w[POT_BIT];
                        end
                    end else begin
                        oe_r  <= 1'b0;
                        cnt_r <= CNT_ZERO;
                        if (!oe_r) begin
                            state_r <= DPSC_IDLE;
                        end else begin
                            case (cmd_r.opcode)
                                OP_RD_WIPER, OP_RD_STORED: begin
                                    // first of the 8 read bits leaves now
                                    tx_r    <= {LEAD_ZERO, rd_val};
                                    oe_r    <= 1'b1;
                                    state_r <= DPSC_RDATA;
                                end
                                OP_WR_WIPER, OP_WR_STORED: begin
                                    state_r <= DPSC_WDATA;
                                end
                                OP_STEP: begin
                                    state_r <= DPSC_STEP;
                                end
                                default: begin
                                    cmd_ready_r <= 1'b1;
                                    state_r     <= DPSC_DONE;
                                end
                            endcase
                        end
                    end
                end
                DPSC_WDATA: begin
                    if (cnt_r != CNT_ACK) begin
                        shift_r <= byte_w;
                        cnt_r   <= cnt_r + CNT_ONE;
                        if (cnt_r == CNT_LAST) begin
                            oe_r       <= 1'b1;
                            cmd_r.data <= byte_w[WIPER_W-1:0];
                        end
                    end else begin
                        oe_r        <= 1'b0;
                        cnt_r       <= CNT_ZERO;
                        cmd_ready_r <= 1'b1;
                        state_r     <= DPSC_DONE;
                    end
                end
                DPSC_RDATA: begin
                    if (cnt_r == CNT_ACK) begin
                        // master acknowledge slot is over
                        cnt_r   <= CNT_ZERO;
                        state_r <= DPSC_DONE;
                    end else if (cnt_r == CNT_LAST) begin
                        oe_r  <= 1'b0;
                        cnt_r <= cnt_r + CNT_ONE;
                    end else begin
                        oe_r  <= ~tx_r[TX_NEXT];
                        tx_r  <= {tx_r[BYTE_W-2:0], 1'b0};
                        cnt_r <= cnt_r + CNT_ONE;
                    end
                end
                DPSC_STEP: begin
                    // one high phase ends here; level seen at its rising edge
                    step_tgl_r <= ~step_tgl_r;
                    step_up_r  <= sda_bit_r;
                end
                default: begin
                    oe_r <= 1'b0;
                end
            endcase
        end
    end

    assign sda_o    = sda_out_r;
    assign sda_oe_o = oe_r;

    // ================= system domain synchronisers =================
    // no reset here: a cleared chain would see a false toggle after reset
    // and replay the last command; the chains settle while reset is held
    always_ff @(posedge clock_i) begin
        stop_s1_r <= stop_tgl_r;
        stop_s2_r <= stop_s1_r;
        stop_s3_r <= stop_s2_r;
        rdy_s1_r  <= cmd_ready_r;
        rdy_s2_r  <= rdy_s1_r;
        step_s1_r <= step_tgl_r;
        step_s2_r <= step_s1_r;
        step_s3_r <= step_s2_r;
    end

    // cmd_r and step_up_r are settled before their flags cross
    assign stop_evt = stop_s2_r ^ stop_s3_r;
    assign step_evt = step_s2_r ^ step_s3_r;
    assign exec     = stop_evt && rdy_s2_r;

    // ================= wiper registers, one per pot =================
    genvar gp;
    generate
        for (gp = 0; gp < NUM_POTS; gp = gp + 1) begin : g_pot
            always_ff @(posedge clock_i) begin
                if (!rstn_i) begin
                    // power-up recall, old value is not kept
                    wiper_position_register_r[gp] <=
                        stored_setting_register_r[stored_index(gp[0], SEL_ZERO)];
                end else if (exec && (cmd_r.pot == gp[0]) && (cmd_r.opcode == OP_WR_WIPER)) begin
                    wiper_position_register_r[gp] <= cmd_r.data;
                end else if (exec && (cmd_r.pot == gp[0]) && (cmd_r.opcode == OP_S2W)) begin
                    wiper_position_register_r[gp] <=
                        stored_setting_register_r[stored_index(cmd_r.pot, cmd_r.sel)];
                end else if (step_evt && (cmd_r.pot == gp[0]) && (cmd_r.opcode == OP_STEP)) begin
                    if (step_up_r && (wiper_position_register_r[gp] != WIPER_MAX)) begin
                        wiper_position_register_r[gp] <= wiper_position_register_r[gp] + WIPER_ONE;
                    end else if (!step_up_r && (wiper_position_register_r[gp] != WIPER_MIN)) begin
                        wiper_position_register_r[gp] <= wiper_position_register_r[gp] - WIPER_ONE;
                    end
                end
            end

            always_ff @(posedge clock_i) begin
                if (!rstn_i) begin
                    tap_r[gp] <= '0;
                end else begin
                    tap_r[gp] <= tap_decode(wiper_position_register_r[gp]);
                end
            end
        end
    endgenerate

    // ================= nonvolatile write cycle =================
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            // a write cut by power loss is simply lost
            busy_r    <= 1'b0;
            nv_cnt_r  <= '0;
            nv_idx_r  <= '0;
            nv_data_r <= '0;
        end else if (!busy_r && exec && (cmd_r.opcode == OP_WR_STORED)) begin
            busy_r    <= 1'b1;
            nv_cnt_r  <= NV_CNT_W'(NV_WRITE_CYCLES_P - 1);
            nv_idx_r  <= stored_index(cmd_r.pot, cmd_r.sel);
            nv_data_r <= cmd_r.data;
        end else if (!busy_r && exec && (cmd_r.opcode == OP_W2S)) begin
            busy_r    <= 1'b1;
            nv_cnt_r  <= NV_CNT_W'(NV_WRITE_CYCLES_P - 1);
            nv_idx_r  <= stored_index(cmd_r.pot, cmd_r.sel);
            nv_data_r <= wiper_position_register_r[cmd_r.pot];
        end else if (busy_r) begin
            if (nv_cnt_r == '0) begin
                busy_r <= 1'b0;
            end else begin
                nv_cnt_r <= nv_cnt_r - NV_CNT_W'(1);
            end
        end
    end

    // new contents appear only when the cycle ends
    always_ff @(posedge clock_i) begin
        if (busy_r && (nv_cnt_r == '0)) begin
            stored_setting_register_r[nv_idx_r] <= nv_data_r;
        end
    end

    assign wiper_position_o = wiper_position_register_r;
    assign tap_select_o     = tap_r;
    assign nv_busy_o        = busy_r;

endmodule : dpsc_top

// ==== verif/dpsc_bus_master.sv ====
// two-wire bus master model that drives the block's bus pins
// assumes an outside pull-up, so a released sda reads high
`timescale 1ns/1ps
module dpsc_bus_master (
    // bus pins
    output logic      scl_o,
    output logic      sda_low_o,
    input  wire logic sda_i
);
    // scl stands still high outside frames
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic start();
        sda_low_o = 1'b1;
        #40 scl_o = 1'b0;
        #20;
    endtask : start
    // sda only moves while scl is low; 80 ns per bit
    task automatic clk_bit(input logic b, output logic r);
        sda_low_o = ~b;
        #20 scl_o = 1'b1;
        #20 r = sda_i;
        #20 scl_o = 1'b0;
        #20;
    endtask : clk_bit
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
        clk_bit(1'b1, r);
        ack = ~r;
    endtask : wbyte
    task automatic rbyte(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
        clk_bit(1'b0, r);
    endtask : rbyte
    // bus free time after stop is kept here
    task automatic stop();
        sda_low_o = 1'b1;
        #20 scl_o = 1'b1;
        #20 sda_low_o = 1'b0;
        #200;
    endtask : stop
endmodule : dpsc_bus_master

// ==== verif/dpsc_top_asserts.sv ====
// assertions on the pins of the dual pot serial command block
// assumes it is bound into dpsc_top and sees its ports only
`timescale 1ns/1ps
module dpsc_top_asserts
    import dpsc_pkg::*;
#(
    parameter int unsigned NV_WRITE_CYCLES_P = NV_WRITE_CYCLES
) (
    // system clock and reset
    input wire logic                              clock_i,
    input wire logic                              rstn_i,
    // two-wire bus
    input wire logic                              scl_i,
    input wire logic                              sda_o,
    input wire logic                              sda_oe_o,
    // potentiometer side
    input wire logic [NUM_POTS-1:0][WIPER_W-1:0] wiper_position_o,
    input wire logic [NUM_POTS-1:0][TAPS-1:0]    tap_select_o,
    input wire logic                              nv_busy_o
);
    logic [31:0] busy_cnt_r;
    // length of the current busy span, zero while idle
    always_ff @(posedge clock_i) begin
        if (!rstn_i || !nv_busy_o) begin
            busy_cnt_r <= 32'h0000_0000;
        end else begin
            busy_cnt_r <= busy_cnt_r + 32'h0000_0001;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    a_tap_pot0: assert property ($past(rstn_i) |-> $onehot(tap_select_o[0]) && tap_select_o[0][$past(wiper_position_o[0])])
        else $error("pot0 tap decode wrong");
    a_tap_pot1: assert property ($past(rstn_i) |-> $onehot(tap_select_o[1]) && tap_select_o[1][$past(wiper_position_o[1])])
        else $error("pot1 tap decode wrong");
    a_reset_clear: assert property (!$past(rstn_i) |-> tap_select_o == '0 && !nv_busy_o)
        else $error("outputs not cleared by reset");
    a_sda_drive_low: assert property (sda_o == 1'b0)
        else $error("sda driven high");
    a_busy_len: assert property ($fell(nv_busy_o) |-> busy_cnt_r == NV_WRITE_CYCLES_P)
        else $error("nonvolatile busy span wrong length");
    a_no_ack_busy: assert property (nv_busy_o |-> !sda_oe_o)
        else $error("sda pulled during nonvolatile write");
    a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("sda drive changed while scl high");
    a_wiper_hold: assert property (nv_busy_o && $past(nv_busy_o) |-> $stable(wiper_position_o))
        else $error("wiper moved during nonvolatile write");
endmodule : dpsc_top_asserts
bind dpsc_top dpsc_top_asserts #(.NV_WRITE_CYCLES_P(NV_WRITE_CYCLES_P)) u_asserts (
    .clock_i(clock_i), .rstn_i(rstn_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .wiper_position_o(wiper_position_o), .tap_select_o(tap_select_o), .nv_busy_o(nv_busy_o));

// ==== verif/dual_pot_serial_command_regs_test.sv ====
// self-checking bench for the dual pot serial command block
// assumes the bus master model and a pull-up on sda
`timescale 1ns/1ps
module dual_pot_serial_command_regs_test;
    import dpsc_pkg::*;
    localparam int unsigned NV_P = 100;  // short nv write keeps the run brief
    logic                             clock_i   = 1'b0;
    logic                             rstn_i    = 1'b0;
    logic [ADDR_MSB:0]                straps    = 4'h3;
    logic [7:0]                       dev_addr  = 8'h63;
    logic                             scl, sda_low, sda, sda_o, sda_oe_o, nv_busy_o;
    logic [NUM_POTS-1:0][WIPER_W-1:0] wiper;
    logic [NUM_POTS-1:0][TAPS-1:0]    taps;
    int                               errors    = 0;
    int                               tests_run = 0;
    always #10 clock_i = ~clock_i;
    assign sda = ~(sda_low | (sda_oe_o & ~sda_o));
    dpsc_top #(.NV_WRITE_CYCLES_P(NV_P)) uut (
        .clock_i(clock_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .device_address_bits_i(straps), .wiper_position_o(wiper),
        .tap_select_o(taps), .nv_busy_o(nv_busy_o));
    dpsc_bus_master m (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask : chk
    // kind 0 two-byte, 1 write data, 2 read data, 3 left open in step mode
    task automatic cmd(input logic [7:0] ins, input logic [7:0] d, input int kind,
                       output logic [7:0] rd, output logic ai);
        logic aa, ad;
        rd = 8'hff;
        ai = 1'b0;
        m.start();
        m.wbyte(dev_addr, aa);
        if (aa) m.wbyte(ins, ai);
        if (ai && kind == 1) begin
            m.wbyte(d, ad);
            chk("data ack", 8'h01, {7'h00, ad});
        end
        if (ai && kind == 2) m.rbyte(rd);
        if (kind != 3 || !ai) m.stop();
    endtask : cmd
    task automatic poll();
        logic aa;
        int   n;
        for (n = 1; n < 20; n++) begin
            m.start();
            m.wbyte(dev_addr, aa);
            m.stop();
            if (aa) break;
        end
        chk("first poll refused", 8'h01, {7'h00, n > 1});
        chk("poll acked in time", 8'h01, {7'h00, n < 20});
    endtask : poll
    task automatic step(input logic [7:0] from, input logic [2:0] pat, input logic [7:0] exp);
        logic [7:0] rd;
        logic       ai, r;
        cmd(8'hA0, from, 1, rd, ai);
        cmd(8'h20, 8'h00, 3, rd, ai);
        chk("step ack", 8'h01, {7'h00, ai});
        for (int i = 2; i >= 0; i--) m.clk_bit(pat[i], r);
        m.stop();
        chk("stepped wiper0", exp, {2'b00, wiper[0]});
    endtask : step
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    initial begin : watchdog
        #1_000_000;
        errors++;
        wrap_up();
    end
    initial begin : main
        logic [7:0] rd;
        logic       ai;
        static logic [7:0] bad [5] = '{8'h64, 8'h73, 8'h10, 8'h80, 8'hf0};
        repeat (3) @(negedge clock_i);
        rstn_i = 1'b1;
        #37;  // link clock unrelated in phase to the system clock
        chk("wiper0 power-up", 8'h00, {2'b00, wiper[0]});
        chk("tap0 low byte", 8'h01, taps[0][7:0]);
        cmd(8'hA1, 8'h2A, 1, rd, ai);
        chk("wiper1 written", 8'h2A, {2'b00, wiper[1]});
        chk("wiper0 untouched", 8'h00, {2'b00, wiper[0]});
        cmd(8'h91, 8'h00, 2, rd, ai);
        chk("wiper1 read", 8'h2A, rd);
        cmd(8'hCD, 8'hD5, 1, rd, ai);
        poll();
        cmd(8'hBD, 8'h00, 2, rd, ai);
        chk("stored pot1 sel3", 8'h15, rd);
        cmd(8'hDD, 8'h00, 0, rd, ai);
        chk("wiper1 from stored", 8'h15, {2'b00, wiper[1]});
        cmd(8'hA0, 8'h07, 1, rd, ai);
        cmd(8'hE0, 8'h00, 0, rd, ai);
        poll();
        cmd(8'hB0, 8'h00, 2, rd, ai);
        chk("stored pot0 sel0", 8'h07, rd);
        step(8'h3E, 3'b110, 8'h3E);
        step(8'h01, 3'b001, 8'h01);
        // wrong straps, wrong type, then undefined opcodes
        for (int i = 0; i < 5; i++) begin
            dev_addr = (i < 2) ? bad[i] : 8'h63;
            cmd((i < 2) ? 8'hA0 : bad[i], 8'h2C, 1, rd, ai);
            chk("refused ack", 8'h00, {7'h00, ai});
            chk("wiper0 kept", 8'h01, {2'b00, wiper[0]});
        end
        // a finished frame just before reset must not be replayed after it
        cmd(8'hA0, 8'h2C, 1, rd, ai);
        chk("wiper0 before reset", 8'h2C, {2'b00, wiper[0]});
        @(negedge clock_i);
        rstn_i = 1'b0;
        repeat (3) @(negedge clock_i);
        rstn_i = 1'b1;
        repeat (4) @(negedge clock_i);
        chk("wiper0 reloaded", 8'h07, {2'b00, wiper[0]});
        chk("wiper1 reloaded", 8'h00, {2'b00, wiper[1]});
        wrap_up();
    end
endmodule : dual_pot_serial_command_regs_test
